// >>> stl_pkg.sv
// Function
// - Compare commanded absolute position, not encoder position, against the travel limit.
// - Test the positive limit only while moving in the positive direction.
// - Test the negative limit only while moving in the negative direction.
// - Check only when enabled and moving; never during a homing move.
// - Checking stays disabled after reset until explicitly enabled.
// - Reset loads limits to plus and minus 2,147,481,647 counts.
// - A violation stops the motor using maximum acceleration as deceleration.
// - Error code 130 for positive overrun, 131 for negative overrun.
// - The disable command stops checking of both limits.
// - The enable command starts checking of both limits unless the same write also sets the disable bit.
// - Host writes and reads back the positive limit.
// - Host reads back the stored negative limit.
// - Host writes a new negative limit replacing the default.
package stl_pkg;

  localparam logic [3:0] STL_REG_POS_LIMIT = 4'h0;
  localparam logic [3:0] STL_REG_NEG_LIMIT = 4'h1;
  localparam logic [3:0] STL_REG_CONTROL   = 4'h2;
  localparam logic [3:0] STL_REG_STATUS    = 4'h3;

  localparam int STL_CTL_ENABLE_BIT  = 0;
  localparam int STL_CTL_DISABLE_BIT = 1;
  localparam int STL_CTL_CLEAR_BIT   = 2;

  localparam int STL_STS_CODE_LSB   = 0;
  localparam int STL_STS_ENABLE_BIT = 8;
  localparam int STL_STS_STOP_BIT   = 9;

  localparam logic signed [31:0] STL_POS_LIMIT_RESET = 32'sh7FFF_F82F;
  localparam logic signed [31:0] STL_NEG_LIMIT_RESET = -32'sh7FFF_F82F;

  localparam logic [7:0] STL_CODE_NONE    = 8'h00;
  localparam logic [7:0] STL_CODE_POS_OVR = 8'h82;
  localparam logic [7:0] STL_CODE_NEG_OVR = 8'h83;

  typedef struct packed {
    logic        moving;
    logic        homing_move;
    logic        dir_positive;
    logic [31:0] commanded_absolute_position;
  } stl_traj_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } stl_bus_t;

endpackage

// >>> stl_checker.sv
`timescale 1ns/10ps
module stl_checker
  import stl_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // Register port.
  input  wire stl_bus_t    bus_in,
  output logic      [31:0] rdata_out,
  // Trajectory generator.
  input  wire stl_traj_t   traj_in,
  // Motion stop and error.
  output logic             max_decel_stop_out,
  output logic       [7:0] error_code_out
);

  typedef enum logic [0:0] {STL_IDLE, STL_HALT} stl_state_t;

  logic signed [31:0] positive_bound_value;
  logic signed [31:0] negative_bound_value;
  logic               check_en;
  logic [7:0]         err_code;
  stl_state_t         state;
  logic               bound_check_enable_cmd;
  logic               bound_check_disable_cmd;
  logic               clear_cmd;
  logic               pos_ovr;
  logic               neg_ovr;
  logic               active;

  // Decodes a write strobe aimed at one register index.
  function automatic logic stl_write_hit(input stl_bus_t   bus,
                                         input logic [3:0] index);
    return bus.wr && (bus.addr == index);
  endfunction

  // Picks the error code to hold; a new overrun wins over a clear.
  function automatic logic [7:0] stl_code_next(input logic       pos_hit,
                                               input logic       neg_hit,
                                               input logic       clear,
                                               input logic [7:0] code);
    logic [7:0] result;
    if (pos_hit) begin
      result = STL_CODE_POS_OVR;
    end else if (neg_hit) begin
      result = STL_CODE_NEG_OVR;
    end else if (clear) begin
      result = STL_CODE_NONE;
    end else begin
      result = code;
    end
    return result;
  endfunction

  assign bound_check_enable_cmd  = stl_write_hit(bus_in, STL_REG_CONTROL)
                                   && bus_in.wdata[STL_CTL_ENABLE_BIT];
  assign bound_check_disable_cmd = stl_write_hit(bus_in, STL_REG_CONTROL)
                                   && bus_in.wdata[STL_CTL_DISABLE_BIT];
  assign clear_cmd               = stl_write_hit(bus_in, STL_REG_CONTROL)
                                   && bus_in.wdata[STL_CTL_CLEAR_BIT];

  assign active  = check_en && traj_in.moving && !traj_in.homing_move;
  assign pos_ovr = active && traj_in.dir_positive
                   && $signed(traj_in.commanded_absolute_position) > positive_bound_value;
  assign neg_ovr = active && !traj_in.dir_positive
                   && $signed(traj_in.commanded_absolute_position) < negative_bound_value;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      positive_bound_value <= STL_POS_LIMIT_RESET;
    end else if (stl_write_hit(bus_in, STL_REG_POS_LIMIT)) begin
      positive_bound_value <= bus_in.wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      negative_bound_value <= STL_NEG_LIMIT_RESET;
    end else if (stl_write_hit(bus_in, STL_REG_NEG_LIMIT)) begin
      negative_bound_value <= bus_in.wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      check_en <= 1'b0;
    end else if (bound_check_disable_cmd) begin
      check_en <= 1'b0;
    end else if (bound_check_enable_cmd) begin
      check_en <= 1'b1;
    end
  end

  // A new overrun wins over a clear in the same cycle.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      err_code <= STL_CODE_NONE;
    end else begin
      err_code <= stl_code_next(pos_ovr, neg_ovr, clear_cmd, err_code);
    end
  end

  // The stop request holds until the trajectory generator reports no motion.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= STL_IDLE;
    end else begin
      case (state)
        STL_IDLE: begin
          if (pos_ovr || neg_ovr) begin
            state <= STL_HALT;
          end
        end
        STL_HALT: begin
          if (!traj_in.moving) begin
            state <= STL_IDLE;
          end
        end
        default: begin
          state <= STL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      max_decel_stop_out <= 1'b0;
      error_code_out     <= STL_CODE_NONE;
    end else begin
      max_decel_stop_out <= (state == STL_HALT && traj_in.moving) || pos_ovr || neg_ovr;
      error_code_out     <= stl_code_next(pos_ovr, neg_ovr, clear_cmd, err_code);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        STL_REG_POS_LIMIT: rdata_out <= positive_bound_value;
        STL_REG_NEG_LIMIT: rdata_out <= negative_bound_value;
        STL_REG_STATUS: begin
          rdata_out                     <= 32'h0000_0000;
          rdata_out[STL_STS_CODE_LSB+:8] <= err_code;
          rdata_out[STL_STS_ENABLE_BIT] <= check_en;
          rdata_out[STL_STS_STOP_BIT]   <= state == STL_HALT;
        end
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

endmodule

// >>> stl_checker_sva.sv
`timescale 1ns/10ps
module stl_checker_sva
  import stl_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire stl_bus_t    bus_in,
  input wire logic [31:0] rdata_out,
  input wire stl_traj_t   traj_in,
  input wire logic        max_decel_stop_out,
  input wire logic [7:0]  error_code_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire clr = bus_in.wr && bus_in.addr == STL_REG_CONTROL && bus_in.wdata[STL_CTL_CLEAR_BIT];
  wire [7:0] ec = error_code_out;
  a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0) else $error("rdata");
  a_code_legal: assert property (ec inside {8'h00, 8'h82, 8'h83}) else $error("code");
  a_pos_cause: assert property ($changed(ec) && ec == 8'h82 |->
    $past(traj_in.moving && traj_in.dir_positive)) else $error("pos");
  a_neg_cause: assert property ($changed(ec) && ec == 8'h83 |->
    $past(traj_in.moving && !traj_in.dir_positive)) else $error("neg");
  a_stop_idle: assert property (!traj_in.moving |=> !max_decel_stop_out) else $error("stop");
  a_stop_code: assert property ($rose(max_decel_stop_out) |-> ec != 8'h00) else $error("sc");
  a_code_hold: assert property (ec != 8'h00 && !clr |=> ec != 8'h00) else $error("hold");
  a_home_quiet: assert property (traj_in.homing_move && ec == 8'h00 |=> ec == 8'h00)
    else $error("home");
  cover property ($rose(max_decel_stop_out));
  cover property (ec == 8'h83);
  cover property (clr);
endmodule
bind stl_checker stl_checker_sva i_stl_checker_sva (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .traj_in(traj_in),
  .max_decel_stop_out(max_decel_stop_out), .error_code_out(error_code_out));

// >>> stl_traj_model.sv
`timescale 1ns/10ps
module stl_traj_model
  import stl_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        go_in,
  input wire logic        home_in,
  input wire logic        dir_in,
  input wire logic [31:0] start_in,
  input wire logic        stop_in,
  output stl_traj_t       traj_out = '0
);
  logic halted = 1'b0;
  // Steps one count a cycle while go is held; a stop request ends the motion.
  always @(posedge mclk_in) begin
    halted <= go_in & (halted | stop_in);
    traj_out.moving <= go_in & ~halted & ~stop_in;
    traj_out.homing_move <= home_in;
    traj_out.dir_positive <= dir_in;
    if (!go_in) begin
      traj_out.commanded_absolute_position <= start_in;
    end else if (traj_out.moving) begin
      traj_out.commanded_absolute_position <=
        traj_out.commanded_absolute_position + (dir_in ? 32'h1 : 32'hFFFF_FFFF);
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top import stl_pkg::*; ;
  logic mclk_in = 0, rst_b_in = 0, go = 0, home = 0, dir = 0, seen = 0, stop;
  logic [31:0] start = 32'h0, rdata;
  logic [7:0] code;
  stl_bus_t bus = '0;
  stl_traj_t traj;
  int error_cnt = 0, compares = 0;
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) seen <= go & (seen | stop);
  stl_checker i_stl_checker (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_in(bus),
    .rdata_out(rdata), .traj_in(traj), .max_decel_stop_out(stop), .error_code_out(code));
  stl_traj_model i_stl_traj_model (.mclk_in(mclk_in), .go_in(go), .home_in(home),
    .dir_in(dir), .start_in(start), .stop_in(stop), .traj_out(traj));
  task cmp_read(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: read %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_motion(input logic got_stop, input logic [7:0] got_code, exp);
    compares++;
    if (got_stop !== (exp != 8'h00) || got_code !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: stop %b code %h exp %h", $time, got_stop, got_code, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in) bus <= '0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_in) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_in) bus <= '0;
    @(negedge mclk_in) cmp_read(rdata, e);
  endtask
  task mv(input logic d, h, input logic [31:0] s, input logic [7:0] e);
    @(posedge mclk_in) {dir, home, start} <= {d, h, s};
    @(posedge mclk_in) go <= 1'b1;
    repeat (30) @(posedge mclk_in);
    @(negedge mclk_in) cmp_motion(seen, code, e);
    @(posedge mclk_in) go <= 1'b0;
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000 error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(STL_REG_POS_LIMIT, 32'h7FFF_F82F);
    rd(STL_REG_NEG_LIMIT, 32'h8000_07D1);
    rd(STL_REG_STATUS, 32'h0);
    wr(STL_REG_POS_LIMIT, 32'h5);
    rd(STL_REG_POS_LIMIT, 32'h5);
    mv(1, 0, 32'h3, 8'h00);
    wr(STL_REG_CONTROL, 32'h1);
    rd(STL_REG_STATUS, 32'h100);
    mv(1, 0, 32'h3, 8'h82);
    rd(STL_REG_STATUS, 32'h182);
    wr(STL_REG_CONTROL, 32'h4);
    wr(STL_REG_NEG_LIMIT, 32'hFFFF_FFFE);
    rd(STL_REG_NEG_LIMIT, 32'hFFFF_FFFE);
    mv(0, 0, 32'hA, 8'h83);
    wr(STL_REG_CONTROL, 32'h4);
    mv(1, 1, 32'h3, 8'h00);
    wr(STL_REG_CONTROL, 32'h3);
    rd(STL_REG_STATUS, 32'h0);
    mv(1, 0, 32'h3, 8'h00);
    rd(4'hF, 32'h0);
    wr(STL_REG_CONTROL, 32'h1);
    mv(1, 0, 32'h3, 8'h82);
    @(posedge mclk_in) rst_b_in <= 1'b0;
    @(posedge mclk_in) rst_b_in <= 1'b1;
    rd(STL_REG_STATUS, 32'h0);
    rd(STL_REG_POS_LIMIT, 32'h7FFF_F82F);
    give_verdict;
  end
endmodule
